//--- rcr_top.sv
/*
 * Rail control register bank for two converters and one linear regulator.
 * Assumes a simple synchronous byte register port from the serial
 * control interface: one-cycle write strobe, read data one cycle later.
 */
`timescale 1ns/10ps
module rcr_top #(
    parameter logic [2:0] SLEEP_PIN_MAP = 3'h0 // Factory pin choice per rail
) (
    input wire logic core_clk, // Clock, 50 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid
    input wire logic sleep_pin_a, // Sleep pin a
    input wire logic sleep_pin_b, // Sleep pin b
    input wire logic [2:0] control_input_pins, // Per-rail enable from pins
    output logic [2:0] rail_enable, // Rail on, index 0 conv five
    output logic [2:0] rail_sleep_code, // Sleep voltage code selected
    output logic conv_five_pwm, // Converter five forced PWM
    output logic conv_six_pwm // Converter six forced PWM
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [5:0] ctrl_ff [rcr_pkg::NUM_RAILS];
    logic [5:0] nxt_ctrl [rcr_pkg::NUM_RAILS];
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic pwm5_ff;
    logic pwm6_ff;
    logic nxt_pwm5;
    logic nxt_pwm6;
    logic [1:0] wr_idx;
    logic wr_hit;
    logic [1:0] rd_idx;
    logic rd_hit;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        wr_idx = 2'h0;
        wr_hit = 1'b0;
        if (reg_addr == rcr_pkg::CONV_FIVE_CTRL_OFS) begin
            wr_idx = 2'h0;
            wr_hit = 1'b1;
        end else if (reg_addr == rcr_pkg::CONV_SIX_CTRL_OFS) begin
            wr_idx = 2'h1;
            wr_hit = 1'b1;
        end else if (reg_addr == rcr_pkg::LINREG_TWO_CTRL_OFS) begin
            wr_idx = 2'h2;
            wr_hit = 1'b1;
        end
        rd_idx = wr_idx;
        rd_hit = wr_hit;
    end

    // ------------------------------------------------------------
    // Register next state
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < rcr_pkg::NUM_RAILS; i++) begin
            nxt_ctrl[i] = ctrl_ff[i];
        end
        // Reserved bits are stored as written; software must keep them fixed
        if (reg_wr && wr_hit) begin
            nxt_ctrl[wr_idx] = reg_wdata[5:0]; // RL9
        end
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            nxt_rdata = rd_hit ? {2'h0, ctrl_ff[rd_idx]} : rcr_pkg::RD_UNMAPPED; // RL9
        end
        nxt_rvalid = reg_rd;
        // Mode 0 on converter five is reserved; hardware still treats 1 as PWM
        nxt_pwm5 = (ctrl_ff[0][rcr_pkg::MODE_BIT] == rcr_pkg::RCR_MODE_PWM); // RL7
        nxt_pwm6 = (ctrl_ff[1][rcr_pkg::MODE_BIT] == rcr_pkg::RCR_MODE_PWM); // RL8
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff[0] <= rcr_pkg::CONV_CTRL_RST[5:0]; // RL4
            ctrl_ff[1] <= rcr_pkg::CONV_CTRL_RST[5:0]; // RL4
            ctrl_ff[2] <= rcr_pkg::LINREG_CTRL_RST[5:0]; // RL5
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
            pwm5_ff <= 1'b0;
            pwm6_ff <= 1'b0;
        end else begin
            for (int i = 0; i < rcr_pkg::NUM_RAILS; i++) begin
                ctrl_ff[i] <= nxt_ctrl[i];
            end
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            pwm5_ff <= nxt_pwm5;
            pwm6_ff <= nxt_pwm6;
        end
    end

    // ------------------------------------------------------------
    // Per-rail control
    // ------------------------------------------------------------
    for (genvar g = 0; g < rcr_pkg::NUM_RAILS; g++) begin : g_rail
        rcr_rail_ctl u_rail (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .sleep_select(ctrl_ff[g][rcr_pkg::SLEEP_SEL_LSB +: 2]),
            .enable_bit(ctrl_ff[g][rcr_pkg::ENABLE_BIT]),
            .pin_select(SLEEP_PIN_MAP[g]),
            .sleep_pin_a(sleep_pin_a),
            .sleep_pin_b(sleep_pin_b),
            .ctl_request(control_input_pins[g]),
            .use_sleep_code(rail_sleep_code[g]),
            .rail_on(rail_enable[g])
        );
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign conv_five_pwm = pwm5_ff;
    assign conv_six_pwm = pwm6_ff;
endmodule // rcr_top

//--- rcr_pkg.sv
/*
 * Constants for the rail control register bank: offsets, field positions,
 * reset values and operating-mode encodings.
 * Assumes a register access port of byte-wide data and 8-bit offsets.
 */
// Overview of operation
// RL1: Sleep-select 00 keeps normal code; 11 uses sleep code while assigned pin low.
// RL2: Software never writes 01 or 10 into a sleep-select field.
// RL3: Each rail follows exactly one sleep pin, fixed at the factory.
// RL4: Converter registers bits 3:2 are always written 11 and reset to 11.
// RL5: Linear regulator register bits 3:1 are always written 110.
// RL6: Enable bit at 0 turns the rail off whatever the control pins say.
// RL7: First converter mode bit 1 selects forced PWM; 0 is reserved.
// RL8: Second converter mode bit 0 is automatic, 1 is forced PWM.
// RL9: Bits 7:6 of every register are read-only zero and ignore writes.
package rcr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CONV_FIVE_CTRL_OFS = 8'h26;
    localparam logic [7:0] CONV_SIX_CTRL_OFS = 8'h27;
    localparam logic [7:0] LINREG_TWO_CTRL_OFS = 8'h28;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SLEEP_SEL_LSB = 4;
    localparam int MODE_BIT = 1;
    localparam int ENABLE_BIT = 0;
    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] CONV_CTRL_RST = 8'h0c;
    localparam logic [7:0] LINREG_CTRL_RST = 8'h0c;
    localparam logic [7:0] WRITABLE_MASK = 8'h3f;
    localparam logic [1:0] SLEEP_SEL_OFF = 2'h0;
    localparam logic [1:0] SLEEP_SEL_ON = 2'h3;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam int NUM_RAILS = 3;
    typedef enum logic {RCR_MODE_AUTO = 1'b0, RCR_MODE_PWM = 1'b1} rcr_mode_e;
endpackage

//--- rcr_rail_ctl.sv
/*
 * Per-rail control: picks normal or sleep voltage code and gates the rail.
 * Assumes the sleep pins and control pins are synchronous to core_clk.
 */
`timescale 1ns/10ps
module rcr_rail_ctl (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Async reset
    input wire logic [1:0] sleep_select, // Sleep-select field
    input wire logic enable_bit, // Software enable
    input wire logic pin_select, // Factory choice: 0 pin a, 1 pin b
    input wire logic sleep_pin_a, // Sleep pin a
    input wire logic sleep_pin_b, // Sleep pin b
    input wire logic ctl_request, // Combined control input pin request
    output logic use_sleep_code, // Sleep code in use
    output logic rail_on // Rail enabled
);
    logic use_sleep_ff;
    logic rail_on_ff;
    logic nxt_use_sleep;
    logic nxt_rail_on;
    logic pin_level;

    always_comb begin
        pin_level = pin_select ? sleep_pin_b : sleep_pin_a; // RL3
        // Reserved codes fall back to normal voltage as the safe choice
        nxt_use_sleep = (sleep_select == rcr_pkg::SLEEP_SEL_ON) && !pin_level; // RL1
        nxt_rail_on = enable_bit && ctl_request; // RL6
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            use_sleep_ff <= 1'b0;
            rail_on_ff <= 1'b0;
        end else begin
            use_sleep_ff <= nxt_use_sleep;
            rail_on_ff <= nxt_rail_on;
        end
    end

    assign use_sleep_code = use_sleep_ff;
    assign rail_on = rail_on_ff;
endmodule // rcr_rail_ctl

//--- rcr_top_props.sv
/*
 * Checker for the rail control register bank, bound to rcr_top.
 * Assumes the one-cycle register port timing of the design.
 */
`timescale 1ns/10ps
module rcr_top_props #(parameter logic [2:0] SLEEP_PIN_MAP = 3'h0) (
    input wire logic core_clk, arst_n, reg_wr, reg_rd, reg_rvalid, // Clock, reset, port
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, // Register port
    input wire logic sleep_pin_a, sleep_pin_b, conv_five_pwm, conv_six_pwm, // Pins
    input wire logic [2:0] control_input_pins, rail_enable, rail_sleep_code // Rails
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    logic [2:0] pin_low;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_low[i] = SLEEP_PIN_MAP[i] ? !sleep_pin_b : !sleep_pin_a;
        end
    end
    sequence wr_five; reg_wr && reg_addr == 8'h26; endsequence
    sequence wr_six; reg_wr && reg_addr == 8'h27; endsequence
    sequence rd_five; reg_rd && reg_addr == 8'h26 && !reg_wr; endsequence
    rd_valid_a: assert property (reg_rd |=> reg_rvalid) else $error("no valid");
    top_zero_a: assert property (reg_rvalid |-> reg_rdata[7:6] == 2'h0)
        else $error("top bits");
    pin_gate_a: assert property ((rail_enable & ~$past(control_input_pins)) == 3'h0)
        else $error("pin gate");
    sleep_gate_a: assert property ((rail_sleep_code & ~$past(pin_low)) == 3'h0)
        else $error("sleep pin");
    five_off_a: assert property (wr_five ##0 !reg_wdata[0] |-> ##2 !rail_enable[0])
        else $error("rail on");
    five_pwm_a: assert property (wr_five |-> ##2 conv_five_pwm == $past(reg_wdata[1], 2))
        else $error("five mode");
    six_mode_a: assert property (wr_six |-> ##2 conv_six_pwm == $past(reg_wdata[1], 2))
        else $error("six mode");
    readback_a: assert property (wr_five ##1 rd_five |=>
        reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)}) else $error("readback");
endmodule // rcr_top_props
bind rcr_top rcr_top_props #(.SLEEP_PIN_MAP(SLEEP_PIN_MAP)) rcr_top_props_i (.*);

//--- rail_control_registers_test.sv
/*
 * Self-checking bench for the rail control register bank.
 * Assumes the default pin map: every rail follows sleep pin a.
 */
`timescale 1ns/10ps
module rail_control_registers_test;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    logic core_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sleep_pin_a = 1'h1;
    logic reg_rvalid, conv_five_pwm, conv_six_pwm;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] control_input_pins = 3'h7, rail_enable, rail_sleep_code;
    logic [12:0] r;
    int bad_count = 0, cmp_count = 0;
    // Rail, write data, pin a, enable, sleep code
    logic [12:0] rows [7] = '{{2'h0, 8'hff, 3'h3}, {2'h0, 8'h0f, 3'h2}, {2'h0, 8'h3e, 3'h1},
        {2'h1, 8'h3d, 3'h3}, {2'h1, 8'h3f, 3'h6}, {2'h2, 8'h3d, 3'h3}, {2'h2, 8'h0c, 3'h0}};
    // Pin b opposite to a, so following the wrong pin shows
    rcr_top rcr_top_i (.*, .sleep_pin_b(!sleep_pin_a));
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1 reg_wr = 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_rd = 1'h1;
        reg_addr = a;
        @(posedge core_clk);
        #1 reg_rd = 1'h0;
        chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
        chk("rdata", reg_rdata, e);
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        forever #10 core_clk = !core_clk;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        #1 arst_n = 1'h1;
        foreach (rows[k]) begin
            r = rows[k];
            sleep_pin_a = r[2];
            wr(8'h26 + {6'h0, r[12:11]}, r[10:3]);
            rd(8'h26 + {6'h0, r[12:11]}, {2'h0, r[8:3]});
            @(posedge core_clk);
            #1 chk("enable", {7'h0, rail_enable[r[12:11]]}, {7'h0, r[1]});
            chk("sleep", {7'h0, rail_sleep_code[r[12:11]]}, {7'h0, r[0]});
            if (r[12:11] != 2'h2) begin
                chk("mode", {7'h0, r[11] ? conv_six_pwm : conv_five_pwm}, {7'h0, r[4]});
            end
        end
        // Rail six still enabled by software; pins alone must drop it
        control_input_pins = 3'h0;
        repeat (2) @(posedge core_clk);
        #1 chk("pins off", {5'h0, rail_enable}, 8'h00);
        rd(8'h29, 8'h00);
        wr(8'h25, 8'hff);
        // Neighbouring offset must leave the last rail untouched
        rd(8'h28, 8'h0c);
        arst_n = 1'h0;
        control_input_pins = 3'h7;
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'h1;
        for (int k = 0; k < 3; k++) begin
            rd(8'h26 + k[7:0], 8'h0c);
        end
        chk("reset", {5'h0, rail_enable}, 8'h00);
        report_and_stop;
    end
endmodule // rail_control_registers_test
